// ===== design/lait_consts.svh
`ifndef LAIT_CONSTS_SVH
`define LAIT_CONSTS_SVH

// ----------------------------------------------------------------
// timing command codes
// ----------------------------------------------------------------
`define LAIT_CMD_INT_D1    8'h00
`define LAIT_CMD_INT_D2    8'h04
`define LAIT_CMD_INT_DIFF  8'h08
`define LAIT_CMD_EXT_D1    8'h30
`define LAIT_CMD_EXT_D2    8'h34
`define LAIT_CMD_EXT_DIFF  8'h38

// ----------------------------------------------------------------
// read byte indices
// ----------------------------------------------------------------
`define LAIT_IDX_RD_LSB    2'h0
`define LAIT_IDX_RD_MSB    2'h1
`define LAIT_IDX_CNT_LSB   2'h2
`define LAIT_IDX_CNT_MSB   2'h3

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define LAIT_SRC_LSB       2
`define LAIT_SRC_MSB       3
`define LAIT_RST_BYTE      8'h00
`define LAIT_RST_WORD      16'h0000

// ----------------------------------------------------------------
// integration count in oscillator cycles, counter width in bits
// ----------------------------------------------------------------
`define LAIT_INT_CYCLES    32768
`define LAIT_CNT_WIDTH     16

`endif

// ===== design/lait_pkg.sv
package lait_pkg;

    typedef enum logic [1:0] {
        LAIT_SRC_D1,
        LAIT_SRC_D2,
        LAIT_SRC_DIFF
    } lait_src_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } lait_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } lait_adc_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] idx;
    } lait_rd_req_t;

    typedef struct packed {
        logic       valid;
        logic       ack;
        logic [7:0] data;
    } lait_rd_rsp_t;

endpackage

// ===== design/lait_osc_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "lait_consts.svh"

module lait_osc_timer #(
    parameter int CNT_W      = `LAIT_CNT_WIDTH,
    parameter int INT_CYCLES = `LAIT_INT_CYCLES
) (
    input  wire logic             osc_clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic             ext,
    input  wire logic             restart_tgl,
    output var  logic             end_tgl_q,
    output var  logic [CNT_W-1:0] count_q
);
    import lait_pkg::*;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(INT_CYCLES - 1);

    logic             rst_s1, osc_rst_n;
    logic             run_s1, run_s2;
    logic             ext_s1, ext_s2;
    logic             rs_s1, rs_s2, rs_s3;
    logic             restart;
    logic             running_q;
    logic [CNT_W-1:0] cnt_q;

    // ----------------------------------------------------------------
    // crossings from the core domain
    // ----------------------------------------------------------------
    always_ff @(posedge osc_clk) begin
        rst_s1    <= rst_n;
        osc_rst_n <= rst_s1;
        run_s1    <= run;
        run_s2    <= run_s1;
        ext_s1    <= ext;
        ext_s2    <= ext_s1;
        rs_s1     <= restart_tgl;
        rs_s2     <= rs_s1;
        rs_s3     <= rs_s2;
    end

    assign restart = rs_s2 ^ rs_s3;

    // ----------------------------------------------------------------
    // integration counter, same oscillator in every mode
    // ----------------------------------------------------------------
    always_ff @(posedge osc_clk) begin
        if (!osc_rst_n) begin
            cnt_q     <= '0;
            running_q <= 1'b0;
            end_tgl_q <= 1'b0;
            count_q   <= '0;
        end else if (!run_s2) begin
            cnt_q     <= '0;
            running_q <= 1'b0;
        end else if (restart) begin
            // command ends the running period and opens the next
            if (running_q) begin
                end_tgl_q <= ~end_tgl_q;
                count_q   <= CNT_W'(cnt_q + 1'b1);
            end
            cnt_q     <= '0;
            running_q <= 1'b1;
        end else if (running_q && !ext_s2 && cnt_q == LAST) begin
            end_tgl_q <= ~end_tgl_q;
            count_q   <= CNT_W'(cnt_q + 1'b1);
            cnt_q     <= '0;
        end else if (running_q) begin
            // wraps silently past full scale
            cnt_q <= CNT_W'(cnt_q + 1'b1);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_int_period_end: assert property (
        @(posedge osc_clk) disable iff (!osc_rst_n)
        (run_s2 && running_q && !ext_s2 && !restart && cnt_q == LAST)
        |=> (cnt_q == '0) && (end_tgl_q != $past(end_tgl_q)))
        else $error("internal period did not end at full count");

    a_ext_cmd_only: assert property (
        @(posedge osc_clk) disable iff (!osc_rst_n)
        (run_s2 && running_q && ext_s2 && !restart && cnt_q == LAST)
        |=> (cnt_q == CNT_W'(LAST + 1'b1)) && $stable(end_tgl_q))
        else $error("external period ended without a command");

    a_restart_clears: assert property (
        @(posedge osc_clk) disable iff (!osc_rst_n)
        (run_s2 && restart) |=> (cnt_q == '0) && running_q)
        else $error("command did not restart the counter");

endmodule
`default_nettype wire

// ===== design/lait_top.sv
// Summary of operation
// - Internal modes end each integration after 32768 oscillator cycles.
// - The nominal 327.6kHz resistor-set oscillator clocks the counter.
// - External modes time each integration from one command to the next.
// - The oscillator runs the same way in internal and external modes.
// - External commands start and stop the integration and 16-bit counter.
// - The last period's count is read as the third and fourth bytes.
// - In external modes only command spacing ends an integration.
// - Codes 00/04/08 pick internal d1/d2/diff, 30/34/38 the external ones.
// - Reads return reading low, reading high, count low, count high.
// - Internal modes refuse the count bytes with a not-acknowledge.
`timescale 1ns/100ps
`default_nettype none
`include "lait_consts.svh"

module lait_top #(
    parameter int CNT_W      = `LAIT_CNT_WIDTH,
    parameter int INT_CYCLES = `LAIT_INT_CYCLES
) (
    input  wire lait_pkg::lait_cmd_t    cmd,
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   osc_clk,
    input  wire lait_pkg::lait_adc_t    adc,
    input  wire lait_pkg::lait_rd_req_t rd_req,
    output var  lait_pkg::lait_rd_rsp_t rd_rsp_q,
    output var  lait_pkg::lait_src_t    src_q,
    output var  logic                   ext_q,
    output var  logic                   active_q,
    output var  logic                   integ_end_q
);
    import lait_pkg::*;

    // ----------------------------------------------------------------
    // command decoding
    // ----------------------------------------------------------------
    function automatic logic is_int_cmd(input logic [7:0] c);
        is_int_cmd = (c == `LAIT_CMD_INT_D1) || (c == `LAIT_CMD_INT_D2)
                  || (c == `LAIT_CMD_INT_DIFF);
    endfunction

    function automatic logic is_ext_cmd(input logic [7:0] c);
        is_ext_cmd = (c == `LAIT_CMD_EXT_D1) || (c == `LAIT_CMD_EXT_D2)
                  || (c == `LAIT_CMD_EXT_DIFF);
    endfunction

    function automatic lait_src_t cmd_src(input logic [7:0] c);
        logic [1:0] f;
        f = c[`LAIT_SRC_MSB:`LAIT_SRC_LSB];
        if (f == 2'h0) begin
            cmd_src = LAIT_SRC_D1;
        end else if (f == 2'h1) begin
            cmd_src = LAIT_SRC_D2;
        end else begin
            cmd_src = LAIT_SRC_DIFF;
        end
    endfunction

    logic             timing_cmd;
    logic             restart_tgl_q;
    logic             osc_end_tgl;
    logic [CNT_W-1:0] osc_count;
    logic             end_s1, end_s2, end_s3;
    logic             end_evt;
    logic [CNT_W-1:0] count_q;
    logic [15:0]      reading_q;

    assign timing_cmd = cmd.valid
                     && (is_int_cmd(cmd.code) || is_ext_cmd(cmd.code));

    // ----------------------------------------------------------------
    // mode register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ext_q    <= 1'b0;
            active_q <= 1'b0;
            src_q    <= LAIT_SRC_D1;
        end else if (timing_cmd) begin
            ext_q    <= is_ext_cmd(cmd.code);
            active_q <= 1'b1;
            src_q    <= cmd_src(cmd.code);
        end
    end

    // ----------------------------------------------------------------
    // restart event towards the oscillator domain
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            restart_tgl_q <= 1'b0;
        end else if (timing_cmd) begin
            restart_tgl_q <= ~restart_tgl_q;
        end
    end

    lait_osc_timer #(
        .CNT_W      (CNT_W),
        .INT_CYCLES (INT_CYCLES)
    ) u_osc (
        .osc_clk     (osc_clk),
        .rst_n       (rst_n),
        .run         (active_q),
        .ext         (ext_q),
        .restart_tgl (restart_tgl_q),
        .end_tgl_q   (osc_end_tgl),
        .count_q     (osc_count)
    );

    // ----------------------------------------------------------------
    // end-of-integration event back from the oscillator domain
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        end_s1 <= osc_end_tgl;
        end_s2 <= end_s1;
        end_s3 <= end_s2;
    end

    assign end_evt = end_s2 ^ end_s3;

    // count word changes with its toggle, then holds steady until the next end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            integ_end_q <= 1'b0;
            count_q     <= `LAIT_RST_WORD;
        end else begin
            integ_end_q <= end_evt;
            if (end_evt && ext_q) begin
                count_q <= osc_count;
            end
        end
    end

    // ----------------------------------------------------------------
    // converter result
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reading_q <= `LAIT_RST_WORD;
        end else if (adc.valid) begin
            reading_q <= adc.data;
        end
    end

    // ----------------------------------------------------------------
    // read bytes
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_rsp_q <= '0;
        end else begin
            rd_rsp_q.valid <= rd_req.valid;
            rd_rsp_q.ack   <= 1'b0;
            rd_rsp_q.data  <= `LAIT_RST_BYTE;
            if (rd_req.valid) begin
                if (rd_req.idx == `LAIT_IDX_RD_LSB) begin
                    rd_rsp_q.ack  <= 1'b1;
                    rd_rsp_q.data <= reading_q[7:0];
                end else if (rd_req.idx == `LAIT_IDX_RD_MSB) begin
                    rd_rsp_q.ack  <= 1'b1;
                    rd_rsp_q.data <= reading_q[15:8];
                end else if (!ext_q) begin
                    rd_rsp_q.ack  <= 1'b0;
                end else if (rd_req.idx == `LAIT_IDX_CNT_LSB) begin
                    rd_rsp_q.ack  <= 1'b1;
                    rd_rsp_q.data <= count_q[7:0];
                end else begin
                    rd_rsp_q.ack  <= 1'b1;
                    rd_rsp_q.data <= count_q[15:8];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_ext_cmd;
        cmd.valid && is_ext_cmd(cmd.code);
    endsequence

    sequence s_end_ext;
        end_evt && ext_q;
    endsequence

    sequence s_rd_count;
        rd_req.valid && rd_req.idx[1] && ext_q;
    endsequence

    a_ext_decode: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_ext_cmd |=> ext_q && active_q && src_q == cmd_src($past(cmd.code)))
        else $error("external command decoded wrongly");

    a_int_decode: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (cmd.valid && cmd.code == `LAIT_CMD_INT_DIFF)
        |=> !ext_q && src_q == LAIT_SRC_DIFF)
        else $error("internal difference command decoded wrongly");

    a_restart_sent: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        timing_cmd |=> restart_tgl_q != $past(restart_tgl_q))
        else $error("timing command did not restart integration");

    a_count_capture: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_end_ext |=> integ_end_q && count_q == $past(osc_count))
        else $error("final count not latched at integration end");

    a_rd_latency: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_req.valid |=> rd_rsp_q.valid
                         ##1 (!rd_rsp_q.valid || $past(rd_req.valid)))
        else $error("read byte not answered on the next cycle");

    a_rd_order: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (rd_req.valid && rd_req.idx == `LAIT_IDX_RD_MSB)
        |=> rd_rsp_q.ack && rd_rsp_q.data == $past(reading_q[15:8]))
        else $error("reading high byte misplaced");

    a_count_bytes: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (s_rd_count and (rd_req.idx == `LAIT_IDX_CNT_MSB))
        |=> rd_rsp_q.ack && rd_rsp_q.data == $past(count_q[15:8]))
        else $error("count high byte misplaced");

    a_int_nak: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (rd_req.valid && rd_req.idx[1] && !ext_q)
        |=> rd_rsp_q.valid && !rd_rsp_q.ack)
        else $error("count byte acknowledged in internal mode");

endmodule
`default_nettype wire

// ===== sim/lait_master_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// bus master issuing timing commands, times its own gaps
// ----------------------------------------------------------------
module lait_master_model (
    input  wire logic                core_clk,
    output var  lait_pkg::lait_cmd_t cmd,
    output var  logic [31:0]         gap_q
);
    import lait_pkg::*;

    initial cmd = '0;
    initial gap_q = 32'h0;

    // core cycles since the last command went out
    always @(posedge core_clk) begin
        gap_q <= cmd.valid ? 32'h1 : gap_q + 32'h1;
    end

    // one-cycle command pulse, code scrambled when idle
    task automatic send(input logic [7:0] code);
        cmd = '{valid: 1'b1, code: code};
        @(negedge core_clk);
        cmd = '{valid: 1'b0, code: ~code};
    endtask

    // callers keep n far below a counter wrap
    task automatic send_at(input int n, input logic [7:0] code);
        while (gap_q < 32'(n)) begin
            @(negedge core_clk);
        end
        send(code);
    endtask
endmodule

`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    import lait_pkg::*;

    logic          core_clk;
    logic          osc_clk;
    logic          rst_n;
    lait_cmd_t     cmd;
    lait_adc_t     adc;
    lait_rd_req_t  rd_req;
    lait_rd_rsp_t  rd_rsp_q;
    lait_src_t     src_q;
    logic          ext_q;
    logic          active_q;
    logic          integ_end_q;
    logic [31:0]   gap_q;
    int            err_count = 0;
    int            num_checks = 0;
    int            cyc = 0;
    int            pulse_cnt = 0;
    int            n;
    int            k;
    logic [7:0]    seed = 8'h5a;
    logic [7:0]    code;
    logic [15:0]   rdg;
    logic [9:0]    exp_q[$];
    logic [7:0]    codes[6] = '{8'h00, 8'h04, 8'h08, 8'h30, 8'h34, 8'h38};

    lait_top #(.CNT_W(16), .INT_CYCLES(64)) DUT (
        .cmd(cmd), .core_clk(core_clk), .rst_n(rst_n), .osc_clk(osc_clk),
        .adc(adc), .rd_req(rd_req), .rd_rsp_q(rd_rsp_q), .src_q(src_q),
        .ext_q(ext_q), .active_q(active_q), .integ_end_q(integ_end_q)
    );

    lait_master_model u_master (
        .core_clk(core_clk), .cmd(cmd), .gap_q(gap_q)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        osc_clk = 1'b0;
        #7.3;
        forever #32 osc_clk = ~osc_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic set_adc(input logic [15:0] d);
        adc = '{valid: 1'b1, data: d};
        @(negedge core_clk);
        adc = '{valid: 1'b0, data: ~d};
    endtask

    // four back-to-back byte reads, answers noted for the monitor
    task automatic read_all(input logic [15:0] r, input logic [15:0] c,
                            input logic ext);
        for (int i = 0; i < 4; i++) begin
            rd_req = '{valid: 1'b1, idx: i[1:0]};
            exp_q.push_back(i < 2 ? {2'b11, r[(i % 2) * 8 +: 8]} :
                            ext ? {2'b11, c[(i % 2) * 8 +: 8]} : 10'h200);
            @(negedge core_clk);
        end
        rd_req = '{valid: 1'b0, idx: 2'h1};
        repeat (2) @(negedge core_clk);
    endtask

    task automatic wait_end(output int cnt);
        cnt = 0;
        do begin
            @(negedge core_clk);
            cnt++;
        end while (integ_end_q !== 1'b1 && cnt < 1000);
        if (cnt >= 1000) check(32'h0, 32'h1);
    endtask

    // ----------------------------------------------------------------
    // monitors and timeout
    // ----------------------------------------------------------------
    always @(negedge core_clk) begin
        if (rd_rsp_q.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(rd_rsp_q, 32'h0);
            end else begin
                check(rd_rsp_q, exp_q.pop_front());
            end
        end
    end

    always @(posedge core_clk) begin
        if (integ_end_q === 1'b1) pulse_cnt++;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish;
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        adc = '0;
        rd_req = '0;
        repeat (20) @(negedge core_clk);
        check({rd_rsp_q, src_q, ext_q, active_q, integ_end_q}, '0);
        rst_n = 1'b1;
        repeat (30) @(negedge core_clk);

        seed = lfsr(seed);
        rdg[15:8] = seed;
        seed = lfsr(seed);
        rdg[7:0] = seed;
        set_adc(rdg);
        u_master.send(8'h00);
        @(negedge core_clk);
        check({ext_q, active_q}, 32'h1);
        read_all(rdg, 16'h0, 1'b0);
        wait_end(n);
        wait_end(n);
        check(n >= 408 && n <= 411, 32'h1);
        $display("test internal_timing done");

        foreach (codes[i]) begin
            u_master.send(codes[i]);
            repeat (45) @(negedge core_clk);
            check({ext_q, src_q}, {codes[i][4], codes[i][3:2]});
        end
        u_master.send(8'hc4);
        repeat (45) @(negedge core_clk);
        check({ext_q, src_q, active_q}, 32'hd);
        $display("test command_codes done");

        for (int j = 0; j < 3; j++) begin
            seed = lfsr(seed);
            k = (j == 0) ? 20 : (j == 1) ? 2 : 2 + seed % 8;
            code = codes[3 + seed % 3];
            seed = lfsr(seed);
            rdg = {seed, ~seed};
            set_adc(rdg);
            u_master.send(code);
            repeat (40) @(negedge core_clk);
            pulse_cnt = 0;
            u_master.send_at(32 * k, code);
            check(pulse_cnt, 32'h0);
            wait_end(n);
            check(n < 60, 32'h1);
            read_all(rdg, 16'(5 * k), 1'b1);
            $display("test external_timing %0d done", k);
        end
        check(exp_q.size(), 32'h0);
        tally_and_finish;
    end
endmodule

`default_nettype wire
